/* include/ram_expansion_pkg.sv */
// Package: constants for the RAM expansion glue logic
package ram_expansion_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned BANK_COUNT = 4;
  localparam int unsigned DATA_WIDTH = 16;
  localparam int unsigned SMALL_ADDR_WIDTH = 7;
  localparam int unsigned LARGE_ADDR_WIDTH = 8;
  localparam int unsigned LOCAL_ADDR_WIDTH = 10;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] REFRESH_ROW_RESET = 8'h00;
  localparam logic [3:0] COL_STROBE_IDLE = 4'hF;

  // ----------------------------------------------------------------
  // Address driver selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_ROW = 2'b00,
    SRC_COL = 2'b01,
    SRC_REFRESH = 2'b10
  } addr_src_type;

endpackage

/* verilog/dram_expansion_array_logic.sv */
// Module: glue logic between the memory controller and the dynamic RAM array
//
// What this block does
// - One shared row strobe to all chips; one of four column strobes picks a bank.
// - Seven muxed address lines to every chip; large variant adds an eighth line.
// - Row strobe passes only during refresh or accesses aimed at this card.
// - Row, column and refresh row addresses are alternative sources, one at a time.
// - Decoder picks source from refresh and column-mux inputs.
// - Refresh row counter advances each time a refresh completes.
// - Sixteen shared data lines plus two parity lines, each reaching one chip per bank.
// - High and low byte write enables each drive half of the array.
// - Transceiver direction follows a buffered memory read command.
// - High byte transceiver enabled when selected and reading or writing high byte.
// - Low byte transceiver enabled when selected and reading or writing low byte.
// - Local address bits 1 to 10 are buffered out to the ROM card connector.
// - ROM card data reaches the shared bus only while its decode is asserted.
`timescale 1ns/1ns
module dram_expansion_array_logic
  import ram_expansion_pkg::*;
#(
  parameter bit LARGE_CHIPS = 1'b0,
  parameter int unsigned ADDR_WIDTH = LARGE_CHIPS ? LARGE_ADDR_WIDTH : SMALL_ADDR_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic row_strobe_n,
  input wire logic [BANK_COUNT-1:0] col_strobe_in_n,
  input wire logic refresh_active_n,
  input wire logic card_select_n,
  input wire logic column_mux_n,
  input wire logic refresh_done_n,
  input wire logic [ADDR_WIDTH-1:0] row_addr,
  input wire logic [ADDR_WIDTH-1:0] col_addr,
  input wire logic high_byte_write_en_n,
  input wire logic low_byte_write_en_n,
  input wire logic memory_read_n,
  input wire logic rom_card_decode_n,
  input wire logic [LOCAL_ADDR_WIDTH:1] local_addr,
  input wire logic [DATA_WIDTH-1:0] rom_card_data,
  input wire logic [DATA_WIDTH-1:0] shared_mem_bus_in,
  input wire logic [DATA_WIDTH-1:0] array_data_in,
  input wire logic high_byte_parity_in,
  input wire logic low_byte_parity_in,
  output logic gated_row_strobe_n,
  output logic [BANK_COUNT-1:0] bank_col_strobe_n,
  output logic [ADDR_WIDTH-1:0] array_addr,
  output logic [1:0] addr_src,
  output logic array_write_high_n,
  output logic array_write_low_n,
  output logic [DATA_WIDTH-1:0] array_data_out,
  output logic [DATA_WIDTH-1:0] array_data_oe_n,
  output logic high_byte_parity_out,
  output logic low_byte_parity_out,
  output logic parity_oe_n,
  output logic xcvr_to_bus,
  output logic high_xcvr_enable_n,
  output logic low_xcvr_enable_n,
  output logic [DATA_WIDTH-1:0] shared_mem_bus_out,
  output logic [DATA_WIDTH-1:0] shared_mem_bus_oe_n,
  output logic [LOCAL_ADDR_WIDTH:1] buffered_local_addr,
  output logic [ADDR_WIDTH-1:0] refresh_row
);

  // ----------------------------------------------------------------
  // Input synchronisers: every pin except clk and reset_n passes two flops
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 9 + BANK_COUNT;
  logic [SYNC_W-1:0] ctl_meta_r;
  logic [SYNC_W-1:0] ctl_r;
  logic [2*ADDR_WIDTH-1:0] addr_meta_r;
  logic [2*ADDR_WIDTH-1:0] addr_r;
  logic [DATA_WIDTH-1:0] rom_meta_r;
  logic [DATA_WIDTH-1:0] rom_r;
  logic [DATA_WIDTH-1:0] bus_meta_r;
  logic [DATA_WIDTH-1:0] bus_r;
  logic [DATA_WIDTH+1:0] arr_meta_r;
  logic [DATA_WIDTH+1:0] arr_r;
  logic [LOCAL_ADDR_WIDTH:1] la_meta_r;
  logic [LOCAL_ADDR_WIDTH:1] la_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctl_meta_r <= '1;
      ctl_r <= '1;
    end else begin
      ctl_meta_r <= {col_strobe_in_n, row_strobe_n, refresh_active_n, card_select_n, column_mux_n,
                     refresh_done_n, high_byte_write_en_n, low_byte_write_en_n, memory_read_n,
                     rom_card_decode_n};
      ctl_r <= ctl_meta_r;
    end
  end

  always_ff @(posedge clk) begin
    addr_meta_r <= {row_addr, col_addr};
    addr_r <= addr_meta_r;
    rom_meta_r <= rom_card_data;
    rom_r <= rom_meta_r;
    bus_meta_r <= shared_mem_bus_in;
    bus_r <= bus_meta_r;
    arr_meta_r <= {high_byte_parity_in, low_byte_parity_in, array_data_in};
    arr_r <= arr_meta_r;
    la_meta_r <= local_addr;
    la_r <= la_meta_r;
  end

  logic [BANK_COUNT-1:0] cas_s;
  logic ras_s, rf_s, sel_s, colmux_s, refresh_done_n_s, hiwe_s, lowe_s, rd_s, romdc_s;
  assign {cas_s, ras_s, rf_s, sel_s, colmux_s, refresh_done_n_s, hiwe_s, lowe_s, rd_s, romdc_s} = ctl_r;

  // ----------------------------------------------------------------
  // Row strobe gating and bank strobes
  // ----------------------------------------------------------------
  logic ras_ok;
  assign ras_ok = !rf_s || !sel_s;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gated_row_strobe_n <= 1'b1;
      bank_col_strobe_n <= COL_STROBE_IDLE;
    end else begin
      gated_row_strobe_n <= ras_s || !ras_ok;
      bank_col_strobe_n <= cas_s;
    end
  end

  // ----------------------------------------------------------------
  // Refresh row counter
  // ----------------------------------------------------------------
  logic refresh_done_n_prev_r;
  logic [ADDR_WIDTH-1:0] refresh_row_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refresh_done_n_prev_r <= 1'b1;
      refresh_row_r <= REFRESH_ROW_RESET[ADDR_WIDTH-1:0];
    end else begin
      refresh_done_n_prev_r <= refresh_done_n_s;
      if (refresh_done_n_prev_r && !refresh_done_n_s)
        refresh_row_r <= refresh_row_r + 1'b1;
    end
  end
  assign refresh_row = refresh_row_r;

  // ----------------------------------------------------------------
  // Address source decoder and driver
  // ----------------------------------------------------------------
  addr_src_type src_nxt;
  always_comb begin
    if (!rf_s)
      src_nxt = SRC_REFRESH;
    else if (!colmux_s)
      src_nxt = SRC_ROW;
    else
      src_nxt = SRC_COL;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      array_addr <= '0;
      addr_src <= SRC_ROW;
    end else begin
      addr_src <= src_nxt;
      case (src_nxt)
        SRC_REFRESH: array_addr <= refresh_row_r;
        SRC_ROW: array_addr <= addr_r[2*ADDR_WIDTH-1:ADDR_WIDTH];
        SRC_COL: array_addr <= addr_r[ADDR_WIDTH-1:0];
        default: array_addr <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Byte write enables and transceivers
  // ----------------------------------------------------------------
  logic hi_en, lo_en;
  assign hi_en = !sel_s && (!rd_s || !hiwe_s);
  assign lo_en = !sel_s && (!rd_s || !lowe_s);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      array_write_high_n <= 1'b1;
      array_write_low_n <= 1'b1;
      xcvr_to_bus <= 1'b0;
      high_xcvr_enable_n <= 1'b1;
      low_xcvr_enable_n <= 1'b1;
    end else begin
      array_write_high_n <= hiwe_s;
      array_write_low_n <= lowe_s;
      xcvr_to_bus <= !rd_s;
      high_xcvr_enable_n <= !hi_en;
      low_xcvr_enable_n <= !lo_en;
    end
  end

  // ----------------------------------------------------------------
  // Data paths: array side and shared bus side
  // ----------------------------------------------------------------
  // Byte lanes drive the array only on a write through their transceiver
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      array_data_out <= '0;
      array_data_oe_n <= '1;
      high_byte_parity_out <= 1'b0;
      low_byte_parity_out <= 1'b0;
      parity_oe_n <= 1'b1;
      shared_mem_bus_out <= '0;
      shared_mem_bus_oe_n <= '1;
      buffered_local_addr <= '0;
    end else begin
      array_data_out <= bus_r;
      array_data_oe_n <= {{8{!(hi_en && rd_s)}}, {8{!(lo_en && rd_s)}}};
      high_byte_parity_out <= 1'b0;
      low_byte_parity_out <= 1'b0;
      parity_oe_n <= 1'b1; // Parity generation sits on the processor board
      buffered_local_addr <= la_r;
      if (!romdc_s) begin
        shared_mem_bus_out <= rom_r;
        shared_mem_bus_oe_n <= '0;
      end else if (!rd_s) begin
        shared_mem_bus_out <= arr_r[DATA_WIDTH-1:0];
        shared_mem_bus_oe_n <= {{8{!hi_en}}, {8{!lo_en}}};
      end else begin
        shared_mem_bus_out <= '0;
        shared_mem_bus_oe_n <= '1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  row_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!ras_s && rf_s && sel_s) |=> gated_row_strobe_n)
    else $error("row strobe leaked to array");
  row_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!ras_s && !rf_s) |=> !gated_row_strobe_n)
    else $error("refresh row strobe lost");
  bank_strobe_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> bank_col_strobe_n == $past(cas_s))
    else $error("column strobe mismatch");
  refresh_src_a: assert property (@(posedge clk) disable iff (!reset_n)
    !rf_s |=> addr_src == SRC_REFRESH && array_addr == $past(refresh_row_r))
    else $error("refresh address not selected");
  row_src_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rf_s && !colmux_s) |=> addr_src == SRC_ROW)
    else $error("row driver not selected");
  counter_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    (refresh_done_n_prev_r && !refresh_done_n_s) |=> refresh_row_r == $past(refresh_row_r) + 1'b1)
    else $error("refresh counter missed step");
  counter_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(refresh_done_n_prev_r && !refresh_done_n_s) |=> $stable(refresh_row_r))
    else $error("refresh counter moved");
  high_xcvr_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> high_xcvr_enable_n == !$past(!sel_s && (!rd_s || !hiwe_s)))
    else $error("high transceiver enable wrong");
  low_xcvr_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> low_xcvr_enable_n == !$past(!sel_s && (!rd_s || !lowe_s)))
    else $error("low transceiver enable wrong");
  direction_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> xcvr_to_bus == !$past(rd_s))
    else $error("transceiver direction wrong");
  rom_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
    romdc_s && rd_s |=> shared_mem_bus_oe_n == '1)
    else $error("bus driven without decode");
  addr_fwd_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> buffered_local_addr == $past(la_r))
    else $error("local address not forwarded");

endmodule // dram_expansion_array_logic

/* tb/mem_ctrl_model.sv */
// Behavioural memory controller, ROM card and array data lines facing the glue logic
`timescale 1ns/1ns
module mem_ctrl_model
  import ram_expansion_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  output logic row_strobe_n,
  output logic [BANK_COUNT-1:0] col_strobe_in_n,
  output logic refresh_active_n,
  output logic card_select_n,
  output logic column_mux_n,
  output logic refresh_done_n,
  output logic [SMALL_ADDR_WIDTH-1:0] row_addr,
  output logic [SMALL_ADDR_WIDTH-1:0] col_addr,
  output logic high_byte_write_en_n,
  output logic low_byte_write_en_n,
  output logic memory_read_n,
  output logic rom_card_decode_n,
  output logic [LOCAL_ADDR_WIDTH:1] local_addr,
  output logic [DATA_WIDTH-1:0] rom_card_data,
  output logic [DATA_WIDTH-1:0] shared_mem_bus_in,
  output logic [DATA_WIDTH-1:0] array_data_in,
  output logic high_byte_parity_in,
  output logic low_byte_parity_in
);
  logic [DATA_WIDTH-1:0] cell_r;

  initial begin
    {row_strobe_n, refresh_active_n, card_select_n, column_mux_n, refresh_done_n} = '1;
    {high_byte_write_en_n, low_byte_write_en_n, memory_read_n, rom_card_decode_n} = '1;
    col_strobe_in_n = 4'hf;
    {row_addr, col_addr, local_addr, rom_card_data, shared_mem_bus_in, cell_r} = '0;
    {high_byte_parity_in, low_byte_parity_in} = 2'b00;
  end

  // Undriven array lines must not hold their last value, so they flip every cycle
  always @(posedge clk) begin
    if (!reset_n) array_data_in <= '0;
    else if (!card_select_n && !memory_read_n) array_data_in <= cell_r;
    else array_data_in <= ~array_data_in;
  end

  task automatic access();
    @(negedge clk);
    {row_strobe_n, refresh_active_n, card_select_n, column_mux_n} = 4'($urandom);
    {high_byte_write_en_n, low_byte_write_en_n, memory_read_n, rom_card_decode_n} = 4'($urandom);
    col_strobe_in_n = ~(4'h1 << $urandom_range(3));
    {row_addr, col_addr, local_addr} = 24'($urandom);
    {rom_card_data, shared_mem_bus_in} = $urandom;
    {high_byte_parity_in, low_byte_parity_in} = 2'($urandom);
    cell_r = 16'($urandom);
  endtask

  // Strobe-only refresh, one row per 256 cycles of 50 ns
  task automatic refresh_cycle();
    @(negedge clk);
    {refresh_active_n, row_strobe_n, card_select_n, memory_read_n} = 4'b0011;
    col_strobe_in_n = 4'hf;
    repeat (4) @(negedge clk);
    refresh_done_n = 1'b0;
    repeat (3) @(negedge clk);
    {refresh_active_n, row_strobe_n, refresh_done_n} = 3'b111;
    repeat (248) @(negedge clk);
  endtask
endmodule // mem_ctrl_model

/* tb/testbench.sv */
// Self-checking bench comparing the glue logic with a reference model
`timescale 1ns/1ns
module testbench;
  import ram_expansion_pkg::*;
  logic clk, reset_n, row_strobe_n, refresh_active_n, card_select_n, column_mux_n, refresh_done_n;
  logic high_byte_write_en_n, low_byte_write_en_n, memory_read_n, rom_card_decode_n, xcvr_to_bus;
  logic high_byte_parity_in, low_byte_parity_in, gated_row_strobe_n, array_write_high_n, array_write_low_n;
  logic high_byte_parity_out, low_byte_parity_out, parity_oe_n, high_xcvr_enable_n, low_xcvr_enable_n;
  logic [3:0] col_strobe_in_n, bank_col_strobe_n;
  logic [1:0] addr_src;
  logic [6:0] row_addr, col_addr, array_addr, refresh_row;
  logic [10:1] local_addr, buffered_local_addr;
  logic [15:0] rom_card_data, shared_mem_bus_in, array_data_in, array_data_out, array_data_oe_n;
  logic [15:0] shared_mem_bus_out, shared_mem_bus_oe_n;
  int n_errors, compares, refreshes;

  dram_expansion_array_logic #(.LARGE_CHIPS(1'b0)) dut_u (.*);
  mem_ctrl_model ctrl_u (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Reference model, applied once inputs have had time to settle
  // ----------------------------------------------------------------
  task automatic check_all();
    logic sel, rd;
    logic [1:0] src;
    sel = !card_select_n;
    rd = !memory_read_n;
    src = !refresh_active_n ? 2'd2 : (!column_mux_n ? 2'd0 : 2'd1);
    check("row strobe", gated_row_strobe_n, row_strobe_n | (refresh_active_n & card_select_n));
    check("col strobes", bank_col_strobe_n, col_strobe_in_n);
    check("addr source", addr_src, src);
    check("array addr", array_addr, src == 2'd2 ? refreshes % 128 : (src == 2'd0 ? row_addr : col_addr));
    check("direction", xcvr_to_bus, rd);
    check("high enable", high_xcvr_enable_n, !(sel && (rd || !high_byte_write_en_n)));
    check("low enable", low_xcvr_enable_n, !(sel && (rd || !low_byte_write_en_n)));
    check("local addr", buffered_local_addr, local_addr);
    check("parity drive", parity_oe_n, 1'b1);
    check("parity out", {high_byte_parity_out, low_byte_parity_out}, 2'b00);
    check("array data", array_data_out, shared_mem_bus_in);
    check("array oe", array_data_oe_n, {{8{!(sel && !rd && !high_byte_write_en_n)}}, {8{!(sel && !rd && !low_byte_write_en_n)}}});
    check("bus oe", shared_mem_bus_oe_n, (!rom_card_decode_n || (sel && rd)) ? 16'h0000 : 16'hffff);
    if (!rom_card_decode_n) check("rom data", shared_mem_bus_out, rom_card_data);
    if (rom_card_decode_n && sel && rd) check("read data", shared_mem_bus_out, array_data_in);
    if (sel && !rd) check("write high", array_write_high_n, high_byte_write_en_n);
    if (sel && !rd) check("write low", array_write_low_n, low_byte_write_en_n);
  endtask

  // Watchdog: the whole run needs about 35k cycles
  initial begin
    #2_500_000;
    n_errors++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    void'($urandom(32'h0000_de17));
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("reset row", refresh_row, 0);
    check("reset strobe", gated_row_strobe_n, 1'b1);
    reset_n = 1'b1;
    for (int phase = 0; phase < 2; phase++) begin
      // Six edges cover the input sync path plus the array data turnaround
      for (int i = 0; i < 100; i++) begin
        ctrl_u.access();
        repeat (6) @(posedge clk);
        @(negedge clk);
        check_all();
      end
      $display("Test random accesses %0d done", phase);
      // 130 refreshes run the 7-bit counter past its wrap
      for (int i = 0; i < 130 && phase == 0; i++) begin
        ctrl_u.refresh_cycle();
        refreshes++;
        check("refresh row", refresh_row, refreshes % 128);
      end
      $display("Test refresh counting %0d done", phase);
    end
    stop_test();
  end
endmodule // testbench
